// ### rtl/gyro_consts.svh
// Timing counts, frame layout and field positions of the gyro serial port
`ifndef GYRO_CONSTS_SVH
`define GYRO_CONSTS_SVH

// System clock period and least gap between frames, in ns
`define CLK_PERIOD_NS   100
`define FRAME_GAP_NS    100
// Least gap rounded up to whole clock cycles, zero for a zero gap
`define GAP_CYC ((`FRAME_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Bits in one frame and the word sent in the very first exchange
`define FRAME_BITS      6'h20
`define FIRST_WORD      32'h00000001

// Command opcodes on bits 31:29 (sensor requests only test bit 29)
`define OP_READ         3'h4
`define OP_WRITE        3'h2
`define CMD_SENSOR_BIT  29

// Command field positions
`define IDX_MSB         25
`define IDX_LSB         17
`define WDATA_MSB       16
`define WDATA_LSB       1

// Response fixed headers on bits 31:29 and payload kind codes
`define HDR_READ        3'h2
`define HDR_WRITE       3'h1
`define HDR_ERROR       3'h0
`define KIND_INVALID    2'h0
`define KIND_VALID      2'h1
`define KIND_SELFTEST   2'h2
`define KIND_REGRW      2'h3
// Bits 25:24 of register and error responses, module select constant
`define RW_MARK         2'h2
`define MODULE_SEL      3'h0

`endif

// ### rtl/gyro_pkg.sv
// Types shared by the gyro serial port modules
package gyro_pkg;

   // Port sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FRAME,
      ST_ADDR
   } state_t;

   // Decoded command kinds
   typedef enum logic [1:0] {
      CMD_SENSOR,
      CMD_READ,
      CMD_WRITE,
      CMD_BAD
   } cmd_kind_t;

endpackage : gyro_pkg

// ### rtl/pin_sync.sv
// Three-stage synchroniser that accepts a change once stages 2 and 3 agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_q;   // First stage, read only by the second
   logic [W-1:0] s2_q;   // Second stage
   logic [W-1:0] s3_q;   // Third stage
   logic [W-1:0] q_d;    // Next filtered value

   // Filtered value follows only when the last two stages agree
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
         q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q[i];
      end
   end

   // Stage registers; reset to the idle level of each pin
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         q    <= INIT;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q    <= q_d;
      end
   end

endmodule : pin_sync

// ### rtl/resp_format.sv
// Builds one 32-bit response word with both odd check bits
`timescale 1ns/1ps
`include "gyro_consts.svh"
module resp_format
   import gyro_pkg::*;
(
   input  wire cmd_kind_t   kind,
   input  wire logic        spi_err,
   input  wire logic        bad_req,
   input  wire logic        no_data,
   input  wire logic [2:0]  tag,
   input  wire logic [1:0]  status,
   input  wire logic [15:0] data,
   input  wire logic [6:0]  fault,
   output logic      [31:0] word
);

   logic [31:0] body;   // Response with both check bits still zero

   // Pick the layout, then fill in the check bits
   always_comb begin
      body = 32'h00000000;
      if (spi_err || bad_req || no_data || kind == CMD_BAD) begin
         // Error layout wins for any error, sensor requests included
         body = {`HDR_ERROR, 1'b0, `KIND_REGRW, `RW_MARK, `MODULE_SEL,
                 2'h0, spi_err, bad_req, no_data, 8'h00, fault, 1'b0};
      end else if (kind == CMD_SENSOR) begin
         // Echo the tag unchanged, then status, rate and faults
         body = {tag, 1'b0, status, data, 2'h0, fault, 1'b0};
      end else begin
         // Read or write layout, module select fixed at zero
         body = {(kind == CMD_READ) ? `HDR_READ : `HDR_WRITE, 1'b0,
                 `KIND_REGRW, `RW_MARK, `MODULE_SEL, data, 4'h0, 1'b0};
      end
      word = body;
      word[28] = ~^body[31:16];   // Upper half odd, bit 28 still zero
      word[0]  = ~^word[31:1];    // Whole word odd
   end

endmodule : resp_format

// ### rtl/gyro_spi_command_response.sv
// Slave command/response serial port of the rate sensor
// Operation
// - Snapshot sensor data on chip select fall
// - Load prepared response after command, on rise
// - Too short gap flags data unavailable
// - Echo sample tag bits unchanged
// - Module select bits always zero
// - Register index used only for reads/writes
// - Read returns indexed register plus next one
// - Write echoes the written value back
// - Bad bit count or parity sets frame error
// - Any error uses the error response layout
// - Invalid command or register raises access error
// - Payload kind code tells payload type
// - Self-test or PLL fault forces invalid code
// - Upper response half has odd parity
// - Whole response word has odd parity
// - Answer comes in the next exchange
// - First exchange returns word 0x00000001
`timescale 1ns/1ps
`include "gyro_consts.svh"
module gyro_spi_command_response
   import gyro_pkg::*;
#(
   parameter int GAP_CYC = `GAP_CYC   // Least frame gap in clock cycles
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe_n,
   input  wire logic [15:0] rate_data,
   input  wire logic        selftest_mode,
   input  wire logic        selftest_bad,
   input  wire logic        pll_fault,
   input  wire logic [6:0]  fault_flags,
   output logic      [8:0]  reg_addr,
   input  wire logic [7:0]  reg_rdata_a,
   input  wire logic [7:0]  reg_rdata_b,
   input  wire logic        reg_index_ok,
   input  wire logic        reg_writable,
   output logic             reg_wr_en,
   output logic      [15:0] reg_wr_data
);

   localparam logic [3:0] GAP_MAX = 4'(GAP_CYC);

   // Synchronised pins, bit 2 chip select, bit 1 clock, bit 0 data
   logic [2:0]  pins_s;
   logic        cs_s, sclk_s, mosi_s;
   logic        cs_prev_q, sclk_prev_q;   // Last filtered levels
   logic        cs_fall, cs_rise, sclk_rise, sclk_fall;

   state_t      st_q, st_d;               // Sequencer state
   logic [31:0] rx_q, rx_d;               // Incoming command shifter
   logic [5:0]  cnt_q, cnt_d;             // Rising edges in this frame
   logic [31:0] tx_q, tx_d;               // Outgoing response shifter
   logic        miso_q, miso_d;           // Data pin driver
   logic        oe_n_q, oe_n_d;           // Low while driving
   logic [3:0]  gap_q, gap_d;             // Cycles since chip select rose
   logic        du_q, du_d;               // Gap too short this frame
   logic [31:0] cmd_q, cmd_d;             // Command held for decoding
   logic        ferr_q, ferr_d;           // Bit count or parity error
   logic [15:0] snap_rate_q, snap_rate_d; // Snapshot of sensor data
   logic [6:0]  snap_flt_q, snap_flt_d;
   logic        snap_stb_q, snap_stb_d;
   logic        snap_pll_q, snap_pll_d;
   logic        snap_stm_q, snap_stm_d;
   logic [8:0]  addr_q, addr_d;           // Register index to memory
   logic        wr_en_q, wr_en_d;         // One-cycle write strobe
   logic [15:0] wr_data_q, wr_data_d;

   cmd_kind_t   kind;                     // Decoded held command
   logic        req_err;                  // Access error of held command
   logic [1:0]  status;                   // Payload kind for sensor data
   logic [15:0] payload;                  // Data field of the response
   logic [31:0] resp_word;                // Response built for next frame

   // Map the opcode bits onto a command kind
   function automatic cmd_kind_t decode_kind(input logic [31:0] c);
      if (c[`CMD_SENSOR_BIT])
         return CMD_SENSOR;
      else if (c[31:29] == `OP_READ)
         return CMD_READ;
      else if (c[31:29] == `OP_WRITE)
         return CMD_WRITE;
      else
         return CMD_BAD;
   endfunction : decode_kind

   // All pins come from the master's domain; chip select idles high
   pin_sync #(
      .W    (3),
      .INIT (3'h4)
   ) u_pins (
      .clk  (clk),
      .rstn (rstn),
      .d    ({cs_n, sclk, mosi}),
      .q    (pins_s)
   );

   assign cs_s      = pins_s[2];
   assign sclk_s    = pins_s[1];
   assign mosi_s    = pins_s[0];
   assign cs_fall   = cs_prev_q & ~cs_s;
   assign cs_rise   = ~cs_prev_q & cs_s;
   // Clock edges only count inside a frame
   assign sclk_rise = ~cs_s & ~sclk_prev_q & sclk_s;
   assign sclk_fall = ~cs_s & sclk_prev_q & ~sclk_s;

   // Decode of the held command against the memory's answers
   always_comb begin
      kind    = decode_kind(cmd_q);
      // Index checks only for register commands
      req_err = (kind == CMD_BAD) ||
                ((kind != CMD_SENSOR) && !reg_index_ok) ||
                ((kind == CMD_WRITE) && !reg_writable);
      // Self-test or PLL trouble marks the rate invalid
      if (snap_stb_q || snap_pll_q)
         status = `KIND_INVALID;
      else if (snap_stm_q)
         status = `KIND_SELFTEST;
      else
         status = `KIND_VALID;
      case (kind)
         CMD_READ:   payload = {reg_rdata_a, reg_rdata_b};
         CMD_WRITE:  payload = cmd_q[`WDATA_MSB:`WDATA_LSB];
         default:    payload = snap_rate_q;
      endcase
   end

   resp_format u_fmt (
      .kind    (kind),
      .spi_err (ferr_q),
      .bad_req (req_err & ~ferr_q),
      .no_data (du_q),
      .tag     ({cmd_q[28], cmd_q[31:30]}),
      .status  (status),
      .data    (payload),
      .fault   (snap_flt_q),
      .word    (resp_word)
   );

   // Next values of the sequencer and shifters
   always_comb begin
      st_d        = st_q;
      rx_d        = rx_q;
      cnt_d       = cnt_q;
      tx_d        = tx_q;
      miso_d      = miso_q;
      oe_n_d      = oe_n_q;
      gap_d       = (gap_q < GAP_MAX) ? gap_q + 4'h1 : gap_q;
      du_d        = du_q;
      cmd_d       = cmd_q;
      ferr_d      = ferr_q;
      snap_rate_d = snap_rate_q;
      snap_flt_d  = snap_flt_q;
      snap_stb_d  = snap_stb_q;
      snap_pll_d  = snap_pll_q;
      snap_stm_d  = snap_stm_q;
      addr_d      = addr_q;
      wr_en_d     = 1'b0;
      wr_data_d   = wr_data_q;
      case (st_q)
         ST_IDLE: begin
            if (cs_fall) begin
               // Freeze sensor state for the answer to this command
               snap_rate_d = rate_data;
               snap_flt_d  = fault_flags;
               snap_stb_d  = selftest_bad;
               snap_pll_d  = pll_fault;
               snap_stm_d  = selftest_mode;
               // Master broke the least gap; report it
               du_d   = (gap_q < GAP_MAX);
               cnt_d  = 6'h00;
               miso_d = tx_q[31];   // MSB ready before the first rise
               oe_n_d = 1'b0;
               st_d   = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (cs_rise) begin
               // Frame closed: hold command, judge count and parity
               oe_n_d = 1'b1;
               cmd_d  = rx_q;
               ferr_d = (cnt_q != `FRAME_BITS) || !(^rx_q);
               addr_d = rx_q[`IDX_MSB:`IDX_LSB];
               gap_d  = 4'h0;
               st_d   = ST_ADDR;
            end else begin
               if (sclk_rise) begin
                  // Sample on rising edges, MSB first
                  rx_d  = {rx_q[30:0], mosi_s};
                  cnt_d = (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
               end
               if (sclk_fall) begin
                  // Change output on falling edges
                  tx_d   = {tx_q[30:0], 1'b0};
                  miso_d = tx_q[30];
               end
            end
         end
         ST_ADDR: begin
            // Memory answered for addr_q; prepare next exchange
            tx_d = resp_word;
            if (kind == CMD_WRITE && !req_err && !ferr_q) begin
               wr_en_d   = 1'b1;
               wr_data_d = cmd_q[`WDATA_MSB:`WDATA_LSB];
            end
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // State registers; the first word waits in the shifter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cs_prev_q   <= 1'b1;
         sclk_prev_q <= 1'b0;
         st_q        <= ST_IDLE;
         rx_q        <= 32'h00000000;
         cnt_q       <= 6'h00;
         tx_q        <= `FIRST_WORD;
         miso_q      <= 1'b0;
         oe_n_q      <= 1'b1;
         gap_q       <= 4'hF;
         du_q        <= 1'b0;
         cmd_q       <= 32'h00000000;
         ferr_q      <= 1'b0;
         snap_rate_q <= 16'h0000;
         snap_flt_q  <= 7'h00;
         snap_stb_q  <= 1'b0;
         snap_pll_q  <= 1'b0;
         snap_stm_q  <= 1'b0;
         addr_q      <= 9'h000;
         wr_en_q     <= 1'b0;
         wr_data_q   <= 16'h0000;
      end else begin
         cs_prev_q   <= cs_s;
         sclk_prev_q <= sclk_s;
         st_q        <= st_d;
         rx_q        <= rx_d;
         cnt_q       <= cnt_d;
         tx_q        <= tx_d;
         miso_q      <= miso_d;
         oe_n_q      <= oe_n_d;
         gap_q       <= gap_d;
         du_q        <= du_d;
         cmd_q       <= cmd_d;
         ferr_q      <= ferr_d;
         snap_rate_q <= snap_rate_d;
         snap_flt_q  <= snap_flt_d;
         snap_stb_q  <= snap_stb_d;
         snap_pll_q  <= snap_pll_d;
         snap_stm_q  <= snap_stm_d;
         addr_q      <= addr_d;
         wr_en_q     <= wr_en_d;
         wr_data_q   <= wr_data_d;
      end
   end

   assign miso        = miso_q;
   assign miso_oe_n   = oe_n_q;
   assign reg_addr    = addr_q;
   assign reg_wr_en   = wr_en_q;
   assign reg_wr_data = wr_data_q;

   // Checks on the sequencer and the response word
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence frame_close;
      st_q == ST_FRAME && cs_rise;
   endsequence
   sequence answer_ready;
      st_q == ST_ADDR ##1 st_q == ST_IDLE && tx_q == $past(resp_word);
   endsequence
   sequence short_gap;
      st_q == ST_IDLE && cs_fall && gap_q < GAP_MAX;
   endsequence

   next_answer_a: assert property (frame_close |=> answer_ready)
      else $error("response not loaded after frame close");
   load_word_a: assert property (
      st_q == ST_ADDR |=> tx_q == $past(resp_word))
      else $error("prepared word not moved into shifter");
   snapshot_a: assert property (
      st_q == ST_IDLE && cs_fall |=> snap_rate_q == $past(rate_data))
      else $error("sensor snapshot missed at select fall");
   gap_flag_a: assert property (short_gap |=> du_q ##1 du_q)
      else $error("short gap not flagged");
   tag_echo_a: assert property (
      st_q == ST_ADDR && kind == CMD_SENSOR && !ferr_q && !du_q |=>
      tx_q[31:29] == {$past(cmd_q[28]), $past(cmd_q[31:30])})
      else $error("sample tag not echoed");
   module_zero_a: assert property (
      st_q == ST_ADDR && resp_word[27:26] == `KIND_REGRW |=>
      tx_q[23:21] == `MODULE_SEL)
      else $error("module select bits not zero");
   upper_odd_a: assert property (st_q == ST_ADDR |=> ^tx_q[31:16])
      else $error("upper half parity even");
   word_odd_a: assert property (st_q == ST_ADDR |=> ^tx_q)
      else $error("response parity even");
   frame_err_a: assert property (
      st_q == ST_ADDR && ferr_q |=> tx_q[31:29] == `HDR_ERROR && tx_q[18])
      else $error("frame error not reported");
   write_echo_a: assert property (
      st_q == ST_ADDR && kind == CMD_WRITE && !req_err && !ferr_q &&
      !du_q |=> tx_q[20:5] == $past(cmd_q[16:1]) && wr_en_q)
      else $error("write value not echoed");

endmodule : gyro_spi_command_response

// ### testbench/spi_master_model.sv
// Serial bus master model that drives command frames into the port
`timescale 1ns/1ps
module spi_master_model (
   input  wire logic clk,
   input  wire logic miso,
   output logic      cs_n,
   output logic      sclk,
   output logic      mosi
);
   // Idle bus: deselected, clock low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   // One frame of nbits clocks, MSB first, after gap cycles deselected
   task automatic xfer(input logic [31:0] cmd, input int nbits,
                       input int gap, output logic [31:0] rsp);
      logic [31:0] sh;
      sh  = cmd;
      rsp = 32'h0;
      repeat (gap) @(posedge clk);
      cs_n <= 1'b0;
      mosi <= sh[31];
      repeat (4) @(posedge clk);
      // Clock count is the caller's choice so bad frames can be sent
      for (int i = 0; i < nbits; i++) begin
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         // Late in the high phase: the port answers through a synchroniser
         rsp = {rsp[30:0], miso};
         sh  = {sh[30:0], ~sh[31]};
         sclk <= 1'b0;
         mosi <= sh[31];
         repeat (4) @(posedge clk);
      end
      cs_n <= 1'b1;
      // A released line must not keep showing its last level
      mosi <= ~sh[31];
   endtask : xfer
endmodule : spi_master_model

// ### testbench/gyro_spi_command_response_tb.sv
// Self-checking bench for the gyro serial command/response port
`timescale 1ns/1ps
module gyro_spi_command_response_tb;
   // One row: command, clock count, gap before it, sensor inputs
   typedef struct packed {
      logic [31:0] cmd;  // Bit 0 set means send a wrong parity
      logic [5:0]  nb;
      logic [4:0]  gap;
      logic [15:0] rate;
      logic        st;
      logic        sb;
      logic        pl;
   } row_t;

   logic        clk;              // System clock
   logic        rstn;             // Reset, active low
   logic        cs_n;             // Chip select from the model
   logic        sclk;             // Serial clock from the model
   logic        mosi;             // Command data
   logic        miso;             // Response data
   logic        miso_oe_n;        // Response enable, active low
   wire         miso_line;        // Data line as the master sees it
   logic [8:0]  reg_addr;         // Register index from the port
   logic        reg_wr_en;        // Write strobe
   logic [15:0] reg_wr_data;      // Write value
   logic [7:0]  mem [512];        // Registers: 0x00-0x1F valid
   row_t        cur = '0;         // Row whose inputs are applied
   logic [31:0] prev;             // Response owed by the next frame
   int          fails;            // Mismatches
   int          samples_checked;  // Comparisons
   int          wr_pulses = 0;    // Write strobes seen

   row_t rows [16] = '{
      '{32'hE000_0000, 6'h20, 5'h0E, 16'h1234, 1'b0, 1'b0, 1'b0},
      '{32'h33FE_0000, 6'h20, 5'h0E, 16'h8001, 1'b1, 1'b0, 1'b0},
      '{32'hB000_0000, 6'h20, 5'h0E, 16'h7FFF, 1'b1, 1'b1, 1'b0},
      '{32'h7000_0000, 6'h20, 5'h0E, 16'h0100, 1'b0, 1'b0, 1'b1},
      '{32'h4025_7DDE, 6'h20, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0},
      '{32'h8024_0000, 6'h20, 5'h0E, 16'h00FF, 1'b0, 1'b0, 1'b0},
      '{32'h9C0A_0000, 6'h20, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0},
      '{32'h83E0_0000, 6'h20, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0},
      '{32'h4006_2222, 6'h20, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0},
      '{32'h0000_0000, 6'h20, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0},
      '{32'h83E0_0001, 6'h20, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0},
      '{32'h2000_0001, 6'h20, 5'h0E, 16'h5555, 1'b0, 1'b0, 1'b0},
      '{32'h8020_0000, 6'h1F, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0},
      '{32'hE000_0000, 6'h21, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0},
      '{32'h6000_0000, 6'h20, 5'h04, 16'h2222, 1'b0, 1'b0, 1'b0},
      '{32'h8024_0000, 6'h20, 5'h0E, 16'h0000, 1'b0, 1'b0, 1'b0}};

   // Gap limit scaled up so a short gap can be made without a missed frame
   gyro_spi_command_response #(.GAP_CYC(8)) dut_u (
      .clk          (clk),
      .rstn         (rstn),
      .cs_n         (cs_n),
      .sclk         (sclk),
      .mosi         (mosi),
      .miso         (miso),
      .miso_oe_n    (miso_oe_n),
      .rate_data    (cur.rate),
      .selftest_mode(cur.st),
      .selftest_bad (cur.sb),
      .pll_fault    (cur.pl),
      .fault_flags  (cur.rate[6:0]),
      .reg_addr     (reg_addr),
      .reg_rdata_a  (mem[reg_addr]),
      .reg_rdata_b  (mem[reg_addr + 9'h001]),
      .reg_index_ok (reg_addr < 9'h020),
      .reg_writable (reg_addr >= 9'h010 && reg_addr < 9'h020),
      .reg_wr_en    (reg_wr_en),
      .reg_wr_data  (reg_wr_data)
   );

   // A released data line floats up to its pull-up level
   assign miso_line = miso_oe_n ? 1'b1 : miso;

   spi_master_model master_u (
      .clk (clk),
      .miso(miso_line),
      .cs_n(cs_n),
      .sclk(sclk),
      .mosi(mosi)
   );

   // Clock at 100 ns
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Register memory writes; two 8-bit registers per 16-bit write
   initial for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'hA5;
   always @(posedge clk) begin
      if (reg_wr_en === 1'b1) begin
         mem[reg_addr]          <= reg_wr_data[15:8];
         mem[reg_addr + 9'h001] <= reg_wr_data[7:0];
         wr_pulses              <= wr_pulses + 1;
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Response the port owes for command c sent as row r
   function automatic logic [31:0] expect_rsp(row_t r, logic [31:0] c);
      logic [31:0] w;
      logic        spi;
      logic        re;
      logic        du;
      logic [8:0]  ix;
      logic [1:0]  kind;
      ix   = c[25:17];
      spi  = r.nb !== 6'h20 || ^c !== 1'b1;
      re   = !spi && !c[29] && !((c[31:29] == 3'h4 && ix < 9'h020) ||
             (c[31:29] == 3'h2 && ix >= 9'h010 && ix < 9'h020));
      du   = r.gap < 5'h08;
      kind = (r.sb || r.pl) ? 2'h0 : (r.st ? 2'h2 : 2'h1);
      if (spi || re || du)
         w = {8'h0E, 5'h00, spi, re, du, 8'h00, r.rate[6:0], 1'b0};
      else if (c[29])
         w = {c[28], c[31:30], 1'b0, kind, r.rate, 2'h0, r.rate[6:0],
              1'b0};
      else if (c[31])
         w = {8'h4E, 3'h0, mem[ix], mem[ix + 9'h001], 5'h00};
      else
         w = {8'h2E, 3'h0, c[16:1], 5'h00};
      w[28] = ~^w[31:16];
      w[0]  = ~^w[31:1];
      return w;
   endfunction : expect_rsp

   // One frame; late moves the rate and fault flag inputs after chip select falls
   task automatic run(input row_t r, input logic late);
      logic [31:0] c;
      logic [31:0] rsp;
      int          n;
      c = {r.cmd[31:1], ~^r.cmd[31:1] ^ r.cmd[0]};
      n = r.nb;
      @(posedge clk);
      cur <= r;
      fork
         master_u.xfer(c, n, r.gap, rsp);
         if (late) begin
            @(negedge cs_n);
            repeat (20) @(posedge clk);
            cur.rate <= ~r.rate;
         end
      join
      // Partial frames carry only part of the owed word
      if (n <= 32)
         chk(rsp, prev >> (32 - n));
      else
         chk(rsp & (32'hFFFF_FFFF << (n - 32)), prev << (n - 32));
      prev = expect_rsp(r, c);
   endtask : run

   // Verdict and end of run
   task automatic tally_and_finish;
      if (fails == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // Hang guard, well past the roughly 5500 cycles the tests need
   initial begin
      repeat (15000) @(posedge clk);
      fails++;
      tally_and_finish;
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      fails = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      prev = 32'h0000_0001;
      foreach (rows[i]) run(rows[i], 1'b0);
      run(rows[0], 1'b1);
      chk(32'(reg_addr), 32'h0000_0012);
      run(rows[0], 1'b0);
      chk(32'(wr_pulses), 32'h1);
      chk(32'(reg_wr_data), 32'h0000_BEEF);
      // Reset in mid-run, then the first word must come back again
      @(posedge clk);
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      chk(32'({miso_oe_n, reg_wr_en, reg_addr, reg_wr_data}),
          32'h0400_0000);
      rstn <= 1'b1;
      prev = 32'h0000_0001;
      run(rows[5], 1'b0);
      run(rows[0], 1'b0);
      tally_and_finish;
   end
endmodule : gyro_spi_command_response_tb
